// file: design/tss_pkg.sv
// constants and types shared by the tape sense status logic
package tss_pkg;

	// register byte addresses, one aligned word each
	localparam logic [7:0] TSS_OFF_DRIVE_STATUS = 8'h00;
	localparam logic [7:0] TSS_OFF_TRACK_ERROR = 8'h04;
	localparam logic [7:0] TSS_OFF_DRIVE_MODE = 8'h08;
	localparam logic [7:0] TSS_OFF_OPERATION_ERROR = 8'h0c;
	localparam logic [7:0] TSS_OFF_SUBSYSTEM_TYPE = 8'h10;
	localparam logic [7:0] TSS_OFF_DRIVE_CAPABILITY = 8'h14;
	localparam logic [7:0] TSS_OFF_READBACK_MODIFIER = 8'h18;
	localparam logic [7:0] TSS_OFF_CONTROL_CAPABILITY = 8'h1c;
	localparam logic [7:0] TSS_OFF_SENSE_CONTROL = 8'h20;

	// field positions as vector indices: sense bit 0 is the msb, index 7
	localparam int TSS_SB1_SEVEN_TRACK = 4;
	localparam int TSS_SB1_LOAD_POINT = 3;
	localparam int TSS_SB1_WRITE_STATUS = 2;
	localparam int TSS_SB1_FILE_PROTECT = 1;
	localparam int TSS_SB3_VERTICAL_PARITY = 7;
	localparam int TSS_SB3_PHASE_ENCODED = 2;
	localparam int TSS_SB3_BACKWARD = 1;
	localparam int TSS_SB4_PROCESSOR_ERROR = 7;
	localparam int TSS_SB4_REJECT_UNIT = 6;
	localparam int TSS_SB4_TAPE_INDICATE = 5;
	localparam int TSS_SB4_LAST_LOOPBACK = 2;
	localparam int TSS_SB4_UNIT_CHECK = 1;
	localparam int TSS_SB6_SEVEN_TRACK = 7;
	localparam int TSS_SB6_DUAL_DENSITY = 5;
	localparam int TSS_SB6_NOT_1600 = 4;

	// sense control register bits, write one to clear
	localparam int TSS_CTL_CLEAR_REJECT = 0;
	localparam int TSS_CTL_CLEAR_INDICATE = 1;
	localparam int TSS_CTL_CLEAR_LOOPBACK = 2;
	localparam int TSS_CTL_CLEAR_TRACK_ERROR = 3;

	// fixed and reset values
	localparam logic [7:0] TSS_SUBSYSTEM_TYPE_VALUE = 8'h40;
	localparam logic [7:0] TSS_BYTE_RESET = 8'h00;
	localparam logic [31:0] TSS_WORD_RESET = 32'h0000_0000;
	localparam logic [7:0] TSS_NRZI_PAIR = 8'h03;
	localparam logic [7:0] TSS_TIE_NORMAL = 8'h00;
	localparam logic [7:0] TSS_TIE_FIRST = 8'h80;
	localparam logic [7:0] TSS_TIE_SECOND = 8'h40;
	localparam logic [7:0] TSS_BUS_NORMAL = 8'h00;
	localparam logic [7:0] TSS_BUS_FIRST = 8'h30;
	localparam logic [7:0] TSS_BUS_SECOND = 8'h10;

	typedef enum logic [2:0] {
		TSS_CMD_NONE = 3'b000,
		TSS_CMD_READ = 3'b001,
		TSS_CMD_READ_BACK = 3'b010,
		TSS_CMD_WRITE = 3'b011,
		TSS_CMD_LOOPBACK = 3'b100,
		TSS_CMD_MOTION = 3'b101
	} tss_cmd_t;

	typedef enum logic [1:0] {
		TSS_DEN_800 = 2'b00,
		TSS_DEN_1600 = 2'b01,
		TSS_DEN_6250 = 2'b10
	} tss_density_t;

	typedef enum logic [1:0] {
		TSS_REC_NRZI9 = 2'b00,
		TSS_REC_PHASE = 2'b01,
		TSS_REC_GROUP = 2'b10,
		TSS_REC_SEVEN = 2'b11
	} tss_rec_t;

	typedef enum logic [1:0] {
		TSS_LVL_NORMAL = 2'b00,
		TSS_LVL_FIRST = 2'b01,
		TSS_LVL_SECOND = 2'b11
	} tss_level_t;

endpackage

// file: design/tss_sense_status.sv
// sense status byte bank with apb register access
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: drive status bit 3 shows selected drive has seven-track feature.
// RULE2: drive status bit 4 shows selected drive at beginning of tape.
// RULE3: drive status bit 5 shows write status, bit 6 write protect.
// RULE4: track error byte loads at end of read, read back, write, loopback.
// RULE5: host ignores track error byte when vertical parity flag is set.
// RULE6: group-coded mode dead track conditions per track.
// RULE7: phase-encoded mode dead track conditions per track.
// RULE8: nine-track nrzi write or loopback sets track bits 6 and 7.
// RULE9: nrzi read: single track plus data check names it, else bits 6,7.
// RULE10: seven-track reads cycle sense level normal, first, second, back.
// RULE11: drive mode bit 5 shows phase-encoded mode.
// RULE12: drive mode bit 6 shows backward motion.
// RULE13: operation error bit 0 on either processor hardware error.
// RULE14: operation error bit 1 when ready drops during tape motion.
// RULE15: operation error bit 2 when end of tape seen moving forward.
// RULE16: operation error bit 5 when last command was loopback.
// RULE17: operation error bit 6 when drive sense carries unit check.
// RULE18: subsystem type bit 0 always zero, bit 1 always one.
// RULE19: capability bit 0 for seven-track drive, never high density.
// RULE20: capability bit 2 when selected drive supports two densities.
// RULE21: capability bit 3 on at 800 or 6250 or seven-track, off at 1600.
// RULE22: capability bits 4 to 7 carry four-bit drive model code.
module tss_sense_status
	import tss_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic drive_seven_track,
	input wire logic beginning_of_tape,
	input wire logic drive_write_status,
	input wire logic drive_file_protect,
	input wire logic drive_ready,
	input wire logic end_of_tape,
	input wire logic forward_motion,
	input wire logic backward_motion,
	input wire logic motion_cmd_active,
	input wire logic drive_unit_check,
	input wire logic first_processor_error,
	input wire logic second_processor_error,
	input wire logic vertical_parity_check,
	input wire logic drive_dual_density,
	input wire tss_density_t drive_density,
	input wire logic high_density_model,
	input wire logic [3:0] drive_model,
	input wire logic cmd_end,
	input wire tss_cmd_t cmd_kind,
	input wire logic data_check,
	input wire logic read_vrc_error,
	input wire logic [7:0] skew_pre,
	input wire logic [7:0] skew_post,
	input wire logic [7:0] ptr_valid,
	input wire logic [7:0] ptr_persist,
	input wire logic [7:0] ptr_at_end,
	input wire logic [7:0] time_sensor_down,
	input wire logic [7:0] envelope_check,
	input wire logic [7:0] corr_run8,
	input wire logic [7:0] nrzi_track,
	output logic [7:0] tu_sense_level,
	output logic [7:0] bus_out_level
);
	tss_tie_if tie ();

	logic setup;
	logic commit;
	logic do_write;
	logic mapped;
	logic [3:0] clear_bits;
	logic ready_seen;
	logic reject_tape_unit;
	logic tape_indicate;
	logic last_loopback;
	logic seven_unit;
	tss_rec_t rec_mode;
	logic [7:0] drive_status_byte;
	logic [7:0] drive_mode_byte;
	logic [7:0] operation_error_byte;
	logic [7:0] drive_capability_byte;
	logic [7:0] read_byte;

	assign setup = psel && !penable;
	assign commit = psel && penable && pready;
	assign do_write = commit && pwrite && paddr == TSS_OFF_SENSE_CONTROL;
	assign clear_bits = do_write ? pwdata[3:0] : 4'h0;

	// seven-track units never come in high density models
	assign seven_unit = drive_seven_track && !high_density_model; // RULE19

	always_comb
	begin
		rec_mode = TSS_REC_NRZI9;
		if (seven_unit)
			rec_mode = TSS_REC_SEVEN;
		else if (drive_density == TSS_DEN_6250)
			rec_mode = TSS_REC_GROUP;
		else if (drive_density == TSS_DEN_1600)
			rec_mode = TSS_REC_PHASE;
	end

	assign tie.cmd_end = cmd_end;
	assign tie.cmd_kind = cmd_kind;
	assign tie.rec_mode = rec_mode;
	assign tie.data_check = data_check;
	assign tie.read_vrc_error = read_vrc_error;
	assign tie.clear_tie = clear_bits[TSS_CTL_CLEAR_TRACK_ERROR];
	assign tie.skew_pre = skew_pre;
	assign tie.skew_post = skew_post;
	assign tie.ptr_valid = ptr_valid;
	assign tie.ptr_persist = ptr_persist;
	assign tie.ptr_at_end = ptr_at_end;
	assign tie.time_sensor_down = time_sensor_down;
	assign tie.envelope_check = envelope_check;
	assign tie.corr_run8 = corr_run8;
	assign tie.nrzi_track = nrzi_track;
	assign tu_sense_level = tie.tu_level;
	assign bus_out_level = tie.bus_level;

	tss_track_error u_track_error (
		.pclk(pclk),
		.presetn(presetn),
		.tie(tie.builder)
	);

	always_comb
	begin
		drive_status_byte = TSS_BYTE_RESET;
		drive_status_byte[TSS_SB1_SEVEN_TRACK] = drive_seven_track; // RULE1
		drive_status_byte[TSS_SB1_LOAD_POINT] = beginning_of_tape; // RULE2
		drive_status_byte[TSS_SB1_WRITE_STATUS] = drive_write_status; // RULE3
		drive_status_byte[TSS_SB1_FILE_PROTECT] = drive_file_protect; // RULE3
	end

	// the parity flag is reported so the host can discard the track byte
	always_comb
	begin
		drive_mode_byte = TSS_BYTE_RESET;
		drive_mode_byte[TSS_SB3_VERTICAL_PARITY] = vertical_parity_check; // RULE5
		drive_mode_byte[TSS_SB3_PHASE_ENCODED] = rec_mode == TSS_REC_PHASE; // RULE11
		drive_mode_byte[TSS_SB3_BACKWARD] = backward_motion; // RULE12
	end

	always_comb
	begin
		operation_error_byte = TSS_BYTE_RESET;
		operation_error_byte[TSS_SB4_PROCESSOR_ERROR] = first_processor_error | second_processor_error; // RULE13
		operation_error_byte[TSS_SB4_REJECT_UNIT] = reject_tape_unit; // RULE14
		operation_error_byte[TSS_SB4_TAPE_INDICATE] = tape_indicate; // RULE15
		operation_error_byte[TSS_SB4_LAST_LOOPBACK] = last_loopback; // RULE16
		operation_error_byte[TSS_SB4_UNIT_CHECK] = drive_unit_check; // RULE17
	end

	always_comb
	begin
		drive_capability_byte = TSS_BYTE_RESET;
		drive_capability_byte[TSS_SB6_SEVEN_TRACK] = seven_unit; // RULE19
		drive_capability_byte[TSS_SB6_DUAL_DENSITY] = drive_dual_density; // RULE20
		drive_capability_byte[TSS_SB6_NOT_1600] = seven_unit || drive_density != TSS_DEN_1600; // RULE21
		drive_capability_byte[3:0] = drive_model; // RULE22
	end

	always_comb
	begin
		mapped = 1'b1;
		read_byte = TSS_BYTE_RESET;
		unique case (paddr)
			TSS_OFF_DRIVE_STATUS: read_byte = drive_status_byte;
			TSS_OFF_TRACK_ERROR: read_byte = tie.tie_byte;
			TSS_OFF_DRIVE_MODE: read_byte = drive_mode_byte;
			TSS_OFF_OPERATION_ERROR: read_byte = operation_error_byte;
			TSS_OFF_SUBSYSTEM_TYPE: read_byte = TSS_SUBSYSTEM_TYPE_VALUE; // RULE18
			TSS_OFF_DRIVE_CAPABILITY: read_byte = drive_capability_byte;
			TSS_OFF_READBACK_MODIFIER: read_byte = TSS_BYTE_RESET;
			TSS_OFF_CONTROL_CAPABILITY: read_byte = TSS_BYTE_RESET;
			TSS_OFF_SENSE_CONTROL: read_byte = TSS_BYTE_RESET;
			default: mapped = 1'b0;
		endcase
	end

	// one wait-free access phase: answer is ready the cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= TSS_WORD_RESET;
		end
		else if (setup)
		begin
			pready <= 1'b1;
			pslverr <= !mapped;
			prdata <= pwrite ? TSS_WORD_RESET : {24'h00_0000, read_byte};
		end
		else if (commit)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= TSS_WORD_RESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ready_seen <= 1'b0;
		else
			ready_seen <= drive_ready;
	end

	// sticky error bits: a new event in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reject_tape_unit <= 1'b0;
		else if (ready_seen && !drive_ready && motion_cmd_active)
			reject_tape_unit <= 1'b1; // RULE14
		else if (clear_bits[TSS_CTL_CLEAR_REJECT])
			reject_tape_unit <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tape_indicate <= 1'b0;
		else if (end_of_tape && forward_motion)
			tape_indicate <= 1'b1; // RULE15
		else if (clear_bits[TSS_CTL_CLEAR_INDICATE])
			tape_indicate <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_loopback <= 1'b0;
		else if (cmd_end && cmd_kind != TSS_CMD_NONE)
			last_loopback <= cmd_kind == TSS_CMD_LOOPBACK; // RULE16
		else if (clear_bits[TSS_CTL_CLEAR_LOOPBACK])
			last_loopback <= 1'b0;
	end
endmodule
`default_nettype wire

// file: design/tss_tie_if.sv
// bundle between the sense registers and the track error builder
`timescale 1ns/100ps
`default_nettype none
interface tss_tie_if;
	import tss_pkg::*;
	logic cmd_end;
	tss_cmd_t cmd_kind;
	tss_rec_t rec_mode;
	logic data_check;
	logic read_vrc_error;
	logic clear_tie;
	logic [7:0] skew_pre;
	logic [7:0] skew_post;
	logic [7:0] ptr_valid;
	logic [7:0] ptr_persist;
	logic [7:0] ptr_at_end;
	logic [7:0] time_sensor_down;
	logic [7:0] envelope_check;
	logic [7:0] corr_run8;
	logic [7:0] nrzi_track;
	logic [7:0] tie_byte;
	logic [7:0] tu_level;
	logic [7:0] bus_level;
	modport builder (
		input cmd_end, cmd_kind, rec_mode, data_check, read_vrc_error, clear_tie,
		input skew_pre, skew_post, ptr_valid, ptr_persist, ptr_at_end,
		input time_sensor_down, envelope_check, corr_run8, nrzi_track,
		output tie_byte, tu_level, bus_level
	);
	modport sink (
		output cmd_end, cmd_kind, rec_mode, data_check, read_vrc_error, clear_tie,
		output skew_pre, skew_post, ptr_valid, ptr_persist, ptr_at_end,
		output time_sensor_down, envelope_check, corr_run8, nrzi_track,
		input tie_byte, tu_level, bus_level
	);
endinterface
`default_nettype wire

// file: design/tss_track_error.sv
// track in error byte builder with seven-track sense level cycle
`timescale 1ns/100ps
`default_nettype none
module tss_track_error
	import tss_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	tss_tie_if.builder tie
);
	logic is_read;
	logic is_write;
	logic [7:0] dead_group;
	logic [7:0] dead_phase;
	logic [7:0] nrzi_less_one;
	logic nrzi_single;
	logic [7:0] next_tie;
	tss_level_t level;
	tss_level_t next_level;

	assign is_read = (tie.cmd_kind == TSS_CMD_READ) || (tie.cmd_kind == TSS_CMD_READ_BACK);
	assign is_write = (tie.cmd_kind == TSS_CMD_WRITE) || (tie.cmd_kind == TSS_CMD_LOOPBACK);

	for (genvar t = 0; t < 8; t++)
	begin : g_track
		assign dead_group[t] = tie.skew_pre[t] | tie.ptr_at_end[t] // RULE6
			| (is_write & tie.time_sensor_down[t])
			| (is_read & tie.skew_post[t] & tie.ptr_valid[t]);
		assign dead_phase[t] = tie.time_sensor_down[t] | tie.skew_pre[t] // RULE7
			| (tie.skew_post[t] & tie.ptr_persist[t]) | tie.ptr_at_end[t]
			| (is_write & tie.envelope_check[t] & (tie.ptr_persist[t] | tie.time_sensor_down[t]))
			| (is_read & tie.corr_run8[t]);
	end

	// more than one flagged track cannot be named, so report the pair
	assign nrzi_less_one = tie.nrzi_track - 8'h01;
	assign nrzi_single = (tie.nrzi_track != 8'h00) && ((tie.nrzi_track & nrzi_less_one) == 8'h00);

	always_comb
	begin
		next_tie = TSS_TIE_NORMAL;
		unique case (tie.rec_mode)
			TSS_REC_GROUP: next_tie = dead_group; // RULE6
			TSS_REC_PHASE: next_tie = dead_phase; // RULE7
			TSS_REC_NRZI9:
			begin
				if (is_write)
					next_tie = TSS_NRZI_PAIR; // RULE8
				else if (tie.data_check && nrzi_single)
					next_tie = tie.nrzi_track; // RULE9
				else
					next_tie = TSS_NRZI_PAIR; // RULE9
			end
			TSS_REC_SEVEN:
			begin
				if (is_read && level == TSS_LVL_FIRST)
					next_tie = TSS_TIE_FIRST; // RULE10
				else if (is_read && level == TSS_LVL_SECOND)
					next_tie = TSS_TIE_SECOND; // RULE10
				else
					next_tie = TSS_TIE_NORMAL; // RULE10
			end
		endcase
	end

	always_comb
	begin
		next_level = level;
		if (tie.read_vrc_error && is_read && tie.rec_mode == TSS_REC_SEVEN)
		begin
			unique case (level)
				TSS_LVL_NORMAL: next_level = TSS_LVL_FIRST; // RULE10
				TSS_LVL_FIRST: next_level = TSS_LVL_SECOND; // RULE10
				TSS_LVL_SECOND: next_level = TSS_LVL_NORMAL; // RULE10
				default: next_level = TSS_LVL_NORMAL;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level <= TSS_LVL_NORMAL;
		else
			level <= next_level;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tie.tu_level <= TSS_TIE_NORMAL;
			tie.bus_level <= TSS_BUS_NORMAL;
		end
		else
		begin
			unique case (next_level)
				TSS_LVL_FIRST:
				begin
					tie.tu_level <= TSS_TIE_FIRST; // RULE10
					tie.bus_level <= TSS_BUS_FIRST;
				end
				TSS_LVL_SECOND:
				begin
					tie.tu_level <= TSS_TIE_SECOND; // RULE10
					tie.bus_level <= TSS_BUS_SECOND;
				end
				default:
				begin
					tie.tu_level <= TSS_TIE_NORMAL;
					tie.bus_level <= TSS_BUS_NORMAL;
				end
			endcase
		end
	end

	// a command end in the clearing cycle still loads the byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tie.tie_byte <= TSS_BYTE_RESET;
		else if (tie.cmd_end && (is_read || is_write))
			tie.tie_byte <= next_tie; // RULE4
		else if (tie.clear_tie)
			tie.tie_byte <= TSS_BYTE_RESET;
	end
endmodule
`default_nettype wire

// file: verification/tss_host_model.sv
// apb host model issuing sense reads and control writes
`timescale 1ns/100ps
`default_nettype none
module tss_host_model
	import tss_pkg::*;
(
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic tie_trusted
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		tie_trusted = 1'b1;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e, output logic ok);
		ok = 1'b0;
		q = 32'h0000_0000;
		e = 1'b0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int n = 0; n < 16 && !ok; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
			begin
				ok = 1'b1;
				q = prdata;
				e = pslverr;
			end
		end
		// parity flag voids the track byte, so the host stops trusting it
		if (ok && !w && a == TSS_OFF_DRIVE_MODE)
			tie_trusted = !q[TSS_SB3_VERTICAL_PARITY];
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

// file: verification/tss_sense_status_checker.sv
// assertion checker for the sense status bank
`timescale 1ns/100ps
`default_nettype none
module tss_sense_status_checker
	import tss_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic drive_seven_track,
	input wire logic high_density_model,
	input wire tss_density_t drive_density,
	input wire logic drive_dual_density,
	input wire logic [3:0] drive_model,
	input wire logic backward_motion,
	input wire logic first_processor_error,
	input wire logic second_processor_error,
	input wire tss_cmd_t cmd_kind,
	input wire logic read_vrc_error,
	input wire logic [7:0] tu_sense_level,
	input wire logic [7:0] bus_out_level
);
	logic rd, sev, n16, perr, hit;
	assign rd = psel && !penable && !pwrite;
	assign sev = drive_seven_track && !high_density_model;
	assign n16 = sev || drive_density != TSS_DEN_1600;
	assign perr = first_processor_error || second_processor_error;
	assign hit = read_vrc_error && sev && (cmd_kind == TSS_CMD_READ || cmd_kind == TSS_CMD_READ_BACK);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY: assert property (psel && !penable |=> pready && prdata[31:8] == 24'h00_0000)
		else $error("no one-cycle answer");
	AST_IDLE: assert property (!psel |=> !pready)
		else $error("answer without request");
	AST_BAD: assert property (psel && !penable && paddr > TSS_OFF_SENSE_CONTROL |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped address accepted");
	AST_MODE: assert property (rd && paddr == TSS_OFF_DRIVE_MODE |=> prdata[2:1] == {!$past(n16), $past(backward_motion)})
		else $error("mode byte wrong");
	AST_OPER: assert property (rd && paddr == TSS_OFF_OPERATION_ERROR |=> prdata[7] == $past(perr))
		else $error("processor error bit wrong");
	AST_CAP: assert property (rd && paddr == TSS_OFF_DRIVE_CAPABILITY |=> prdata[7] == $past(sev) && prdata[5:0] == {$past(drive_dual_density), $past(n16), $past(drive_model)})
		else $error("capability byte wrong");
	AST_STEP1: assert property (hit && tu_sense_level == TSS_TIE_NORMAL |=> tu_sense_level == TSS_TIE_FIRST && bus_out_level == TSS_BUS_FIRST)
		else $error("first level step wrong");
	AST_STEP2: assert property (hit && tu_sense_level == TSS_TIE_FIRST |=> tu_sense_level == TSS_TIE_SECOND && bus_out_level == TSS_BUS_SECOND)
		else $error("second level step wrong");
	AST_HOLD: assert property (!hit |=> $stable(tu_sense_level) && $stable(bus_out_level))
		else $error("level moved without error");
endmodule
bind tss_sense_status tss_sense_status_checker tss_sense_status_checker_i (.*);
`default_nettype wire

// file: verification/tss_sense_status_tb_top.sv
// self-checking bench for the sense status bank
`timescale 1ns/100ps
`default_nettype none
module tss_sense_status_tb_top
	import tss_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tie_trusted;
	logic [7:0] paddr, tu_sense_level, bus_out_level;
	logic [31:0] pwdata, prdata;
	logic drive_seven_track, beginning_of_tape, drive_write_status, drive_file_protect, drive_ready, end_of_tape;
	logic forward_motion, backward_motion, motion_cmd_active, drive_unit_check, first_processor_error;
	logic second_processor_error, vertical_parity_check, drive_dual_density, high_density_model, cmd_end;
	logic data_check, read_vrc_error;
	logic [3:0] drive_model;
	logic [7:0] skew_pre, skew_post, ptr_valid, ptr_persist, ptr_at_end, time_sensor_down, envelope_check;
	logic [7:0] corr_run8, nrzi_track;
	tss_density_t drive_density;
	tss_cmd_t cmd_kind;
	int error_cnt = 0;
	int n_tests = 0;
	tss_sense_status tss_sense_status_i (.*);
	tss_host_model tss_host_model_i (.*);
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [7:0] exp, input logic ee);
		logic [31:0] q;
		logic e, ok;
		tss_host_model_i.xfer(w, a, d, q, e, ok);
		if (!ok)
		begin
			error_cnt++;
			$display("mismatch pready expected 1 seen 0");
			final_report();
		end
		chk($sformatf("reg %h", a), {24'h00_0000, exp}, q);
		chk("slave error", 32'(ee), 32'(e));
	endtask
	task automatic pulse(input tss_cmd_t k);
		cmd_kind <= k;
		cmd_end <= 1'b1;
		@(posedge pclk);
		cmd_end <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic tr(input tss_cmd_t k, input tss_density_t d, input logic dc, input logic [7:0] sp, sq, pv, cr, nt, exp);
		drive_density <= d;
		data_check <= dc;
		skew_pre <= sp;
		skew_post <= sq;
		ptr_valid <= pv;
		corr_run8 <= cr;
		nrzi_track <= nt;
		pulse(k);
		xf(1'b0, TSS_OFF_TRACK_ERROR, 32'h0000_0000, exp, 1'b0);
	endtask
	task automatic t_status();
		drive_seven_track <= 1'b1;
		beginning_of_tape <= 1'b1;
		drive_file_protect <= 1'b1;
		@(posedge pclk);
		xf(1'b0, TSS_OFF_DRIVE_STATUS, 32'h0000_0000, 8'h1a, 1'b0);
		drive_seven_track <= 1'b0;
		beginning_of_tape <= 1'b0;
		drive_file_protect <= 1'b0;
		drive_write_status <= 1'b1;
		@(posedge pclk);
		xf(1'b0, TSS_OFF_DRIVE_STATUS, 32'h0000_0000, 8'h04, 1'b0);
		xf(1'b1, TSS_OFF_SUBSYSTEM_TYPE, 32'hffff_ffff, 8'h00, 1'b0);
		xf(1'b0, TSS_OFF_SUBSYSTEM_TYPE, 32'h0000_0000, TSS_SUBSYSTEM_TYPE_VALUE, 1'b0);
		xf(1'b0, 8'h24, 32'h0000_0000, 8'h00, 1'b1);
		drive_density <= TSS_DEN_1600;
		backward_motion <= 1'b1;
		vertical_parity_check <= 1'b1;
		@(posedge pclk);
		xf(1'b0, TSS_OFF_DRIVE_MODE, 32'h0000_0000, 8'h86, 1'b0);
		chk("host trust", 32'h0000_0000, 32'(tie_trusted));
		vertical_parity_check <= 1'b0;
		@(posedge pclk);
		xf(1'b0, TSS_OFF_DRIVE_MODE, 32'h0000_0000, 8'h06, 1'b0);
		chk("host trust", 32'h0000_0001, 32'(tie_trusted));
		$display("status and mode done");
	endtask
	task automatic t_cap();
		drive_seven_track <= 1'b1;
		drive_model <= 4'h9;
		@(posedge pclk);
		xf(1'b0, TSS_OFF_DRIVE_CAPABILITY, 32'h0000_0000, 8'h99, 1'b0);
		high_density_model <= 1'b1;
		drive_dual_density <= 1'b1;
		drive_model <= 4'h6;
		@(posedge pclk);
		xf(1'b0, TSS_OFF_DRIVE_CAPABILITY, 32'h0000_0000, 8'h26, 1'b0);
		drive_seven_track <= 1'b0;
		drive_density <= TSS_DEN_6250;
		drive_model <= 4'he;
		@(posedge pclk);
		xf(1'b0, TSS_OFF_DRIVE_CAPABILITY, 32'h0000_0000, 8'h3e, 1'b0);
		$display("capability done");
	endtask
	task automatic t_oper();
		first_processor_error <= 1'b1;
		drive_unit_check <= 1'b1;
		motion_cmd_active <= 1'b1;
		drive_ready <= 1'b0;
		end_of_tape <= 1'b1;
		forward_motion <= 1'b1;
		@(posedge pclk);
		drive_ready <= 1'b1;
		end_of_tape <= 1'b0;
		first_processor_error <= 1'b0;
		second_processor_error <= 1'b1;
		pulse(TSS_CMD_LOOPBACK);
		xf(1'b0, TSS_OFF_OPERATION_ERROR, 32'h0000_0000, 8'he6, 1'b0);
		xf(1'b1, TSS_OFF_SENSE_CONTROL, 32'h0000_0003, 8'h00, 1'b0);
		second_processor_error <= 1'b0;
		drive_unit_check <= 1'b0;
		pulse(TSS_CMD_READ);
		xf(1'b0, TSS_OFF_OPERATION_ERROR, 32'h0000_0000, 8'h00, 1'b0);
		$display("operation errors done");
	endtask
	task automatic t_track();
		high_density_model <= 1'b0;
		tr(TSS_CMD_WRITE, TSS_DEN_800, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h03);
		tr(TSS_CMD_READ, TSS_DEN_800, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20);
		tr(TSS_CMD_LOOPBACK, TSS_DEN_800, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h03);
		tr(TSS_CMD_READ_BACK, TSS_DEN_800, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h03);
		tr(TSS_CMD_READ, TSS_DEN_800, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h03);
		tr(TSS_CMD_READ, TSS_DEN_1600, 1'b0, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h10);
		tr(TSS_CMD_WRITE, TSS_DEN_1600, 1'b0, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00);
		tr(TSS_CMD_READ, TSS_DEN_6250, 1'b0, 8'h00, 8'h40, 8'h40, 8'h00, 8'h00, 8'h40);
		tr(TSS_CMD_WRITE, TSS_DEN_6250, 1'b0, 8'h01, 8'h40, 8'h40, 8'h00, 8'h00, 8'h01);
		tr(TSS_CMD_MOTION, TSS_DEN_6250, 1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
		{ptr_at_end, time_sensor_down, envelope_check, ptr_persist} <= {8'h02, 8'h04, 8'h08, 8'h88};
		tr(TSS_CMD_WRITE, TSS_DEN_1600, 1'b0, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h8e);
		tr(TSS_CMD_READ_BACK, TSS_DEN_1600, 1'b0, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h86);
		tr(TSS_CMD_READ, TSS_DEN_6250, 1'b0, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h02);
		tr(TSS_CMD_WRITE, TSS_DEN_6250, 1'b0, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h06);
		{ptr_at_end, time_sensor_down, envelope_check, ptr_persist} <= '0;
		$display("track byte done");
	endtask
	task automatic t_level();
		logic [7:0] tu[3] = '{TSS_TIE_FIRST, TSS_TIE_SECOND, TSS_TIE_NORMAL};
		logic [7:0] bo[3] = '{TSS_BUS_FIRST, TSS_BUS_SECOND, TSS_BUS_NORMAL};
		drive_seven_track <= 1'b1;
		cmd_kind <= TSS_CMD_READ;
		@(posedge pclk);
		for (int i = 0; i < 3; i++)
		begin
			read_vrc_error <= 1'b1;
			@(posedge pclk);
			read_vrc_error <= 1'b0;
			@(posedge pclk);
			chk("drive level", 32'(tu[i]), 32'(tu_sense_level));
			chk("bus level", 32'(bo[i]), 32'(bus_out_level));
			tr(TSS_CMD_READ, TSS_DEN_800, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, tu[i]);
		end
		$display("sense level done");
	endtask
	initial
	begin
		{drive_seven_track, beginning_of_tape, drive_write_status, drive_file_protect, end_of_tape} = '0;
		{forward_motion, backward_motion, motion_cmd_active, drive_unit_check, first_processor_error} = '0;
		{second_processor_error, vertical_parity_check, drive_dual_density, high_density_model, cmd_end} = '0;
		{data_check, read_vrc_error, drive_model, skew_pre, skew_post, ptr_valid, ptr_persist} = '0;
		{ptr_at_end, time_sensor_down, envelope_check, corr_run8, nrzi_track} = '0;
		drive_ready = 1'b1;
		drive_density = TSS_DEN_800;
		cmd_kind = TSS_CMD_NONE;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_status();
		t_cap();
		t_oper();
		t_track();
		t_level();
		final_report();
	end
endmodule
`default_nettype wire
